// *** shared/gw_defines.svh ***
// Offsets, field positions, codes and reset values of the thread gateway.
`ifndef GW_DEFINES_SVH
`define GW_DEFINES_SVH

// ****************************************************************
// Message opcodes presented on the message port
// ****************************************************************
`define GW_OP_OPEN 4'h0
`define GW_OP_CLOSE 4'h1
`define GW_OP_FORWARD 4'h2

// ****************************************************************
// Payload field positions
// ****************************************************************
`define GW_DW4_LO 128
`define GW_DW5_LO 160
`define GW_OFS_REG_HI 28
`define GW_OFS_REG_LO 21
`define GW_OFS_SUB_HI 20
`define GW_OFS_SUB_LO 16
`define GW_LEN_HI 10
`define GW_LEN_LO 8
`define GW_UNIT_HI 27
`define GW_UNIT_LO 24
`define GW_THREAD_HI 18
`define GW_THREAD_LO 16

// ****************************************************************
// Segment length codes and writeback error codes
// ****************************************************************
`define GW_LEN_BYTE 3'h0
`define GW_LEN_WORD 3'h1
`define GW_LEN_DW1 3'h2
`define GW_LEN_DW2 3'h3
`define GW_LEN_DW4 3'h4
`define GW_ERR_OK 3'h0
`define GW_ERR_OPCODE 3'h5

// ****************************************************************
// Register byte offsets and reset values
// ****************************************************************
`define GW_REG_CTRL 5'h00
`define GW_REG_SFID 5'h04
`define GW_REG_WAKE 5'h08
`define GW_REG_STATUS 5'h0C
`define GW_REG_MSGCNT 5'h10
`define GW_REG_DROPCNT 5'h14
`define GW_CTRL_RST 32'h0000_0001
`define GW_SFID_RST 4'h0
`define GW_WAKE_RST 8'h01

`endif

// *** shared/gw_pkg.sv ***
// Types shared by the thread gateway modules.
package gw_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} state_type;
  typedef struct packed {
    logic [7:0] base;
    logic [7:0] count;
  } entry_type;
endpackage

// *** shared/gw_mem_if.sv ***
// Port bundle between the gateway control and its channel entry table.
`timescale 1ns/1ps
`default_nettype none
interface gw_mem_if #(parameter int IDX_W = 7);
  logic rd_en;
  logic [IDX_W-1:0] rd_idx;
  logic rd_open;
  gw_pkg::entry_type rd_entry;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic wr_open;
  gw_pkg::entry_type wr_entry;
  modport owner(output rd_en, rd_idx, wr_en, wr_idx, wr_open, wr_entry,
                input rd_open, rd_entry);
  modport mem(input rd_en, rd_idx, wr_en, wr_idx, wr_open, wr_entry,
              output rd_open, rd_entry);
endinterface
`default_nettype wire

// *** rtl/gw_entry_mem.sv ***
// Channel entry table: one open flag, base and notify count per thread.
`timescale 1ns/1ps
`default_nettype none
module gw_entry_mem #(
  parameter int IDX_W = 7
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  gw_mem_if.mem port
);
  localparam int DEPTH = 1 << IDX_W;

  // Open flags need a reset value; the payload array does not.
  logic [DEPTH-1:0] open_r;
  logic [DEPTH-1:0] open_nxt;
  gw_pkg::entry_type data_r [DEPTH];
  gw_pkg::entry_type rd_entry_r;
  logic rd_open_r;

  // Next open vector: a write replaces the addressed flag.
  always_comb begin
    open_nxt = open_r;
    if (port.wr_en) begin
      open_nxt[port.wr_idx] = port.wr_open;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      open_r <= '0;
      rd_open_r <= 1'b0;
    end else begin
      open_r <= open_nxt;
      if (port.rd_en) begin
        rd_open_r <= open_r[port.rd_idx];
      end
    end
  end

  // Payload array and its registered read port.
  always_ff @(posedge i_clk) begin
    if (port.wr_en) begin
      data_r[port.wr_idx] <= port.wr_entry;
    end
    if (port.rd_en) begin
      rd_entry_r <= data_r[port.rd_idx];
    end
  end

  assign port.rd_open = rd_open_r;
  assign port.rd_entry = rd_entry_r;
endmodule // gw_entry_mem
`default_nettype wire

// *** rtl/gw_segment_pack.sv ***
// Places a forwarded data segment at its byte position within a register.
`timescale 1ns/1ps
`default_nettype none
`include "gw_defines.svh"
module gw_segment_pack (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic [2:0] i_len,
  input wire logic [4:0] i_sub,
  input wire logic [127:0] i_seg,
  output logic o_we,
  output logic [31:0] o_be,
  output logic [255:0] o_data
);
  logic we_r;
  logic we_nxt;
  logic [31:0] be_r;
  logic [31:0] be_nxt;
  logic [255:0] data_r;
  logic [255:0] data_nxt;

  // Byte lanes covered by a segment of the given length code.
  function automatic logic [31:0] len_mask(input logic [2:0] len);
    case (len)
      `GW_LEN_BYTE: len_mask = 32'h0000_0001;
      `GW_LEN_WORD: len_mask = 32'h0000_0003;
      `GW_LEN_DW1: len_mask = 32'h0000_000F;
      `GW_LEN_DW2: len_mask = 32'h0000_00FF;
      `GW_LEN_DW4: len_mask = 32'h0000_FFFF;
      default: len_mask = 32'h0000_0000;
    endcase
  endfunction

  // Shift mask and data to the sub-register offset; the sender keeps the
  // offset aligned, so a misaligned offset only shifts lanes, never wraps.
  always_comb begin
    we_nxt = i_start;
    be_nxt = be_r;
    data_nxt = data_r;
    if (i_start) begin
      be_nxt = len_mask(i_len) << i_sub;
      data_nxt = {128'h0, i_seg} << {i_sub, 3'b000};
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      we_r <= 1'b0;
      be_r <= '0;
      data_r <= '0;
    end else begin
      we_r <= we_nxt;
      be_r <= be_nxt;
      data_r <= data_nxt;
    end
  end

  assign o_we = we_r;
  assign o_be = be_r;
  assign o_data = data_r;
endmodule // gw_segment_pack
`default_nettype wire

// *** rtl/thread_gateway_close_forward.sv ***
// Thread gateway: channel close, data forwarding, writeback and notify.
`timescale 1ns/1ps
`default_nettype none
`include "gw_defines.svh"

module thread_gateway_close_forward (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic [4:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_MSG_VALID,
  output logic O_MSG_READY,
  input wire logic [3:0] I_MSG_OPCODE,
  input wire logic [3:0] I_MSG_UNIT,
  input wire logic [2:0] I_MSG_THREAD,
  input wire logic I_MSG_ACK_REQ,
  input wire logic I_MSG_NOTIFY,
  input wire logic [255:0] I_MSG_PAYLOAD,
  output logic O_WB_VALID,
  output logic [3:0] O_WB_UNIT,
  output logic [2:0] O_WB_THREAD,
  output logic [31:0] O_WB_DWORD,
  output logic O_RF_WE,
  output logic [3:0] O_RF_UNIT,
  output logic [2:0] O_RF_THREAD,
  output logic [7:0] O_RF_REG,
  output logic [31:0] O_RF_BYTE_EN,
  output logic [255:0] O_RF_DATA,
  output logic O_NOTIFY_VALID,
  output logic O_WAKE_VALID,
  output logic [3:0] O_NOTE_UNIT,
  output logic [2:0] O_NOTE_THREAD
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  gw_pkg::state_type state_r, state_nxt;
  logic [3:0] op_r, op_nxt;
  logic [6:0] req_r, req_nxt;
  logic [6:0] rcp_r, rcp_nxt;
  logic ack_r, ack_nxt;
  logic notify_r, notify_nxt;
  logic [31:0] dw5_r, dw5_nxt;
  logic [127:0] seg_r, seg_nxt;
  logic wb_valid_r, wb_valid_nxt;
  logic [6:0] wb_idx_r, wb_idx_nxt;
  logic [31:0] wb_dword_r, wb_dword_nxt;
  logic [6:0] rf_idx_r, rf_idx_nxt;
  logic [7:0] rf_reg_r, rf_reg_nxt;
  logic note_r, note_nxt;
  logic wake_r, wake_nxt;
  logic [2:0] last_err_r, last_err_nxt;
  logic pack_start;
  logic [7:0] cnt_inc;
  logic msg_inc;
  logic drop_inc;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [3:0] sfid_r, sfid_nxt;
  logic [7:0] wake_thr_r, wake_thr_nxt;
  logic [31:0] msg_cnt_r, msg_cnt_nxt;
  logic [31:0] drop_cnt_r, drop_cnt_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] merged;
  logic bus_ack_r, bus_ack_nxt;
  logic bus_req;
  logic bus_wr;
  logic [31:0] status;
  logic [2:0] len;
  logic len_ok;

  gw_mem_if #(.IDX_W(7)) mem_port ();

  // Byte-lane merge of a bus write into a register.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

  // ****************************************************************
  // Message sequencer
  // ****************************************************************

  // Entry lookup starts at accept, so its read data land in execute.
  assign O_MSG_READY = (state_r == gw_pkg::ST_IDLE) && ctrl_r[0];
  assign len = dw5_r[`GW_LEN_HI:`GW_LEN_LO];
  assign len_ok = (len <= `GW_LEN_DW4);
  assign cnt_inc = mem_port.rd_entry.count + 8'h01;
  assign mem_port.rd_en = I_MSG_VALID && O_MSG_READY;
  // Close names only the requester; forward names the recipient.
  assign mem_port.rd_idx = (I_MSG_OPCODE == `GW_OP_FORWARD) ?
    {I_MSG_PAYLOAD[`GW_DW4_LO+`GW_UNIT_HI:`GW_DW4_LO+`GW_UNIT_LO],
     I_MSG_PAYLOAD[`GW_DW4_LO+`GW_THREAD_HI:`GW_DW4_LO+`GW_THREAD_LO]} :
    {I_MSG_UNIT, I_MSG_THREAD};

  // Next state of the sequencer, entry updates and outgoing pulses.
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    req_nxt = req_r;
    rcp_nxt = rcp_r;
    ack_nxt = ack_r;
    notify_nxt = notify_r;
    dw5_nxt = dw5_r;
    seg_nxt = seg_r;
    wb_valid_nxt = 1'b0;
    wb_idx_nxt = wb_idx_r;
    wb_dword_nxt = wb_dword_r;
    rf_idx_nxt = rf_idx_r;
    rf_reg_nxt = rf_reg_r;
    note_nxt = 1'b0;
    wake_nxt = 1'b0;
    last_err_nxt = last_err_r;
    pack_start = 1'b0;
    msg_inc = 1'b0;
    drop_inc = 1'b0;
    mem_port.wr_en = 1'b0;
    mem_port.wr_idx = req_r;
    mem_port.wr_open = 1'b0;
    mem_port.wr_entry = '0;
    case (state_r)
      gw_pkg::ST_IDLE: begin
        if (I_MSG_VALID && O_MSG_READY) begin
          op_nxt = I_MSG_OPCODE;
          req_nxt = {I_MSG_UNIT, I_MSG_THREAD};
          rcp_nxt = mem_port.rd_idx;
          ack_nxt = I_MSG_ACK_REQ;
          notify_nxt = I_MSG_NOTIFY;
          // Dispatch id and other ignored dwords are never looked at.
          dw5_nxt = I_MSG_PAYLOAD[`GW_DW5_LO +: 32];
          seg_nxt = I_MSG_PAYLOAD[127:0];
          msg_inc = 1'b1;
          state_nxt = gw_pkg::ST_EXEC;
        end
      end
      gw_pkg::ST_EXEC: begin
        state_nxt = gw_pkg::ST_DONE;
        wb_idx_nxt = req_r;
        wb_dword_nxt = {12'h000, sfid_r, 13'h0000, `GW_ERR_OK};
        last_err_nxt = `GW_ERR_OK;
        if (op_r == `GW_OP_OPEN) begin
          mem_port.wr_en = 1'b1;
          mem_port.wr_open = 1'b1;
          mem_port.wr_entry.base = dw5_r[`GW_OFS_REG_HI:`GW_OFS_REG_LO];
          wb_valid_nxt = ack_r;
        end else if (op_r == `GW_OP_CLOSE) begin
          mem_port.wr_en = 1'b1;
          mem_port.wr_open = 1'b0;
          wb_valid_nxt = ack_r;
        end else if (op_r == `GW_OP_FORWARD) begin
          mem_port.wr_idx = rcp_r;
          mem_port.wr_open = 1'b1;
          mem_port.wr_entry = mem_port.rd_entry;
          // A closed channel or reserved length is refused and counted.
          if (mem_port.rd_open && len_ok) begin
            pack_start = 1'b1;
            rf_idx_nxt = rcp_r;
            rf_reg_nxt = mem_port.rd_entry.base +
                         dw5_r[`GW_OFS_REG_HI:`GW_OFS_REG_LO];
            wb_valid_nxt = ack_r;
            if (notify_r) begin
              mem_port.wr_en = 1'b1;
              note_nxt = 1'b1;
              mem_port.wr_entry.count = cnt_inc;
              // The notify that reaches the threshold wakes the thread.
              if (cnt_inc >= wake_thr_r) begin
                wake_nxt = 1'b1;
                mem_port.wr_entry.count = 8'h00;
              end
            end
          end else begin
            drop_inc = 1'b1;
          end
        end else begin
          wb_dword_nxt[2:0] = `GW_ERR_OPCODE;
          last_err_nxt = `GW_ERR_OPCODE;
          wb_valid_nxt = ack_r;
        end
      end
      gw_pkg::ST_DONE: begin
        state_nxt = gw_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = gw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_r <= gw_pkg::ST_IDLE;
      op_r <= 4'h0;
      req_r <= 7'h00;
      rcp_r <= 7'h00;
      ack_r <= 1'b0;
      notify_r <= 1'b0;
      dw5_r <= 32'h0000_0000;
      seg_r <= '0;
      wb_valid_r <= 1'b0;
      wb_idx_r <= 7'h00;
      wb_dword_r <= 32'h0000_0000;
      rf_idx_r <= 7'h00;
      rf_reg_r <= 8'h00;
      note_r <= 1'b0;
      wake_r <= 1'b0;
      last_err_r <= `GW_ERR_OK;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      req_r <= req_nxt;
      rcp_r <= rcp_nxt;
      ack_r <= ack_nxt;
      notify_r <= notify_nxt;
      dw5_r <= dw5_nxt;
      seg_r <= seg_nxt;
      wb_valid_r <= wb_valid_nxt;
      wb_idx_r <= wb_idx_nxt;
      wb_dword_r <= wb_dword_nxt;
      rf_idx_r <= rf_idx_nxt;
      rf_reg_r <= rf_reg_nxt;
      note_r <= note_nxt;
      wake_r <= wake_nxt;
      last_err_r <= last_err_nxt;
    end
  end

  // ****************************************************************
  // Submodules
  // ****************************************************************
  gw_entry_mem #(.IDX_W(7)) u_mem (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .port(mem_port.mem)
  );

  gw_segment_pack u_pack (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_start(pack_start),
    .i_len(len),
    .i_sub(dw5_r[`GW_OFS_SUB_HI:`GW_OFS_SUB_LO]),
    .i_seg(seg_r),
    .o_we(O_RF_WE),
    .o_be(O_RF_BYTE_EN),
    .o_data(O_RF_DATA)
  );

  // ****************************************************************
  // Register bus slave
  // ****************************************************************

  // Every access waits exactly one cycle, giving read data a register.
  assign bus_req = I_AVS_READ || I_AVS_WRITE;
  assign bus_wr = I_AVS_WRITE && bus_ack_r;
  assign O_AVS_WAITREQUEST = bus_req && !bus_ack_r;
  assign status = {25'h000_0000, last_err_r, 3'h0,
                   state_r != gw_pkg::ST_IDLE};

  // Register updates; a counter event in the cycle of its clear survives.
  always_comb begin
    bus_ack_nxt = bus_req && !bus_ack_r;
    ctrl_nxt = ctrl_r;
    sfid_nxt = sfid_r;
    wake_thr_nxt = wake_thr_r;
    msg_cnt_nxt = msg_cnt_r + {31'h0000_0000, msg_inc};
    drop_cnt_nxt = drop_cnt_r + {31'h0000_0000, drop_inc};
    rdata_nxt = rdata_r;
    merged = 32'h0000_0000;
    if (bus_wr) begin
      if (I_AVS_ADDRESS == `GW_REG_CTRL) begin
        merged = merge(ctrl_r, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        ctrl_nxt = {31'h0000_0000, merged[0]};
      end else if (I_AVS_ADDRESS == `GW_REG_SFID) begin
        merged = merge({28'h000_0000, sfid_r}, I_AVS_WRITEDATA,
                       I_AVS_BYTEENABLE);
        sfid_nxt = merged[3:0];
      end else if (I_AVS_ADDRESS == `GW_REG_WAKE) begin
        merged = merge({24'h00_0000, wake_thr_r}, I_AVS_WRITEDATA,
                       I_AVS_BYTEENABLE);
        wake_thr_nxt = merged[7:0];
      end else if (I_AVS_ADDRESS == `GW_REG_MSGCNT) begin
        msg_cnt_nxt = {31'h0000_0000, msg_inc};
      end else if (I_AVS_ADDRESS == `GW_REG_DROPCNT) begin
        drop_cnt_nxt = {31'h0000_0000, drop_inc};
      end
    end
    if (I_AVS_READ && !bus_ack_r) begin
      if (I_AVS_ADDRESS == `GW_REG_CTRL) begin
        rdata_nxt = ctrl_r;
      end else if (I_AVS_ADDRESS == `GW_REG_SFID) begin
        rdata_nxt = {28'h000_0000, sfid_r};
      end else if (I_AVS_ADDRESS == `GW_REG_WAKE) begin
        rdata_nxt = {24'h00_0000, wake_thr_r};
      end else if (I_AVS_ADDRESS == `GW_REG_STATUS) begin
        rdata_nxt = status;
      end else if (I_AVS_ADDRESS == `GW_REG_MSGCNT) begin
        rdata_nxt = msg_cnt_r;
      end else if (I_AVS_ADDRESS == `GW_REG_DROPCNT) begin
        rdata_nxt = drop_cnt_r;
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      bus_ack_r <= 1'b0;
      ctrl_r <= `GW_CTRL_RST;
      sfid_r <= `GW_SFID_RST;
      wake_thr_r <= `GW_WAKE_RST;
      msg_cnt_r <= 32'h0000_0000;
      drop_cnt_r <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
    end else begin
      bus_ack_r <= bus_ack_nxt;
      ctrl_r <= ctrl_nxt;
      sfid_r <= sfid_nxt;
      wake_thr_r <= wake_thr_nxt;
      msg_cnt_r <= msg_cnt_nxt;
      drop_cnt_r <= drop_cnt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_AVS_READDATA = rdata_r;
  assign O_WB_VALID = wb_valid_r;
  assign O_WB_UNIT = wb_idx_r[6:3];
  assign O_WB_THREAD = wb_idx_r[2:0];
  assign O_WB_DWORD = wb_dword_r;
  assign O_RF_UNIT = rf_idx_r[6:3];
  assign O_RF_THREAD = rf_idx_r[2:0];
  assign O_RF_REG = rf_reg_r;
  assign O_NOTIFY_VALID = note_r;
  assign O_WAKE_VALID = wake_r;
  assign O_NOTE_UNIT = rf_idx_r[6:3];
  assign O_NOTE_THREAD = rf_idx_r[2:0];
endmodule // thread_gateway_close_forward
`default_nettype wire

// *** verification/gw_checker_properties.sv ***
// Concurrent checks on the ports of the thread gateway.
`timescale 1ns/1ps
`default_nettype none
`include "gw_defines.svh"
module gw_checker (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic I_MSG_VALID,
  input wire logic O_MSG_READY,
  input wire logic [3:0] I_MSG_OPCODE,
  input wire logic [3:0] I_MSG_UNIT,
  input wire logic I_MSG_ACK_REQ,
  input wire logic I_MSG_NOTIFY,
  input wire logic [255:0] I_MSG_PAYLOAD,
  input wire logic O_WB_VALID,
  input wire logic [3:0] O_WB_UNIT,
  input wire logic [31:0] O_WB_DWORD,
  input wire logic O_RF_WE,
  input wire logic [3:0] O_RF_UNIT,
  input wire logic [2:0] O_RF_THREAD,
  input wire logic [31:0] O_RF_BYTE_EN,
  input wire logic O_NOTIFY_VALID,
  input wire logic O_WAKE_VALID
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  logic [255:0] tk_pay;
  logic tk_note;
  // Last taken message, for outputs that follow it two cycles on.
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tk_pay <= '0;
      tk_note <= 1'b0;
    end else if (I_MSG_VALID && O_MSG_READY) begin
      tk_pay <= I_MSG_PAYLOAD;
      tk_note <= I_MSG_NOTIFY;
    end
  end
  // ****************************************************************
  // Sequences and properties
  // ****************************************************************
  sequence s_take;
    I_MSG_VALID && O_MSG_READY;
  endsequence
  sequence s_close(logic ack);
    s_take ##0 (I_MSG_OPCODE == `GW_OP_CLOSE && I_MSG_ACK_REQ == ack);
  endsequence
  property p_wait_first;
    $rose(I_AVS_READ || I_AVS_WRITE) |-> O_AVS_WAITREQUEST;
  endproperty
  property p_ready_gap;
    s_take |=> !O_MSG_READY [*2];
  endproperty
  property p_close_ack;
    s_close(1'b1) |-> ##2 (O_WB_VALID && O_WB_DWORD[2:0] == `GW_ERR_OK
      && O_WB_UNIT == $past(I_MSG_UNIT, 2));
  endproperty
  property p_close_quiet;
    s_close(1'b0) |-> ##1 !O_WB_VALID ##1 !O_WB_VALID;
  endproperty
  property p_bad_op;
    s_take ##0 (I_MSG_OPCODE > `GW_OP_FORWARD && I_MSG_ACK_REQ)
      |-> ##2 (O_WB_VALID && O_WB_DWORD[2:0] == `GW_ERR_OPCODE);
  endproperty
  property p_wb_layout;
    O_WB_VALID |-> (O_WB_DWORD[31:20] == '0 && O_WB_DWORD[15:3] == '0);
  endproperty
  property p_rf_target;
    O_RF_WE |-> (O_RF_UNIT == tk_pay[155:152]
      && O_RF_THREAD == tk_pay[146:144] && O_RF_BYTE_EN[tk_pay[180:176]]);
  endproperty
  property p_rf_low;
    O_RF_WE |-> (O_RF_BYTE_EN & ((32'h0000_0001 << tk_pay[180:176])
      - 32'h0000_0001)) == '0;
  endproperty
  property p_note_src;
    O_NOTIFY_VALID |-> (tk_note && O_RF_WE);
  endproperty
  property p_wake_note;
    O_WAKE_VALID |-> O_NOTIFY_VALID;
  endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("waitrequest low in first cycle of access");
  a_ready_gap: assert property (p_ready_gap)
    else $error("message ready too soon after accept");
  a_close_ack: assert property (p_close_ack)
    else $error("close writeback missing or wrong");
  a_close_quiet: assert property (p_close_quiet)
    else $error("writeback sent without request");
  a_bad_op: assert property (p_bad_op)
    else $error("opcode error code missing");
  a_wb_layout: assert property (p_wb_layout)
    else $error("reserved writeback bits set");
  a_rf_target: assert property (p_rf_target)
    else $error("register write to wrong thread or lane");
  a_rf_low: assert property (p_rf_low)
    else $error("lanes below the offset enabled");
  a_note_src: assert property (p_note_src)
    else $error("notify without flagged forward");
  a_wake_note: assert property (p_wake_note)
    else $error("wake without notify");
endmodule // gw_checker
`default_nettype wire

// *** verification/gw_thread_model.sv ***
// Model of the requesting threads that offer gateway messages.
`timescale 1ns/1ps
`default_nettype none
module gw_thread_model (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic [3:0] o_opcode,
  output logic [3:0] o_unit,
  output logic [2:0] o_thread,
  output logic o_ack,
  output logic o_notify,
  output logic [255:0] o_payload
);
  initial begin
    o_valid = 1'b0;
    o_opcode = 4'h0;
    o_unit = 4'h0;
    o_thread = 3'h0;
    o_ack = 1'b0;
    o_notify = 1'b0;
    o_payload = '0;
  end
  // Held until the accepting edge, then opcode and payload flipped so stale values show.
  task automatic send(input logic [3:0] op, input logic [3:0] unit,
      input logic [2:0] thr, input logic ack, input logic note,
      input logic [255:0] pay);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_opcode <= op;
    o_unit <= unit;
    o_thread <= thr;
    o_ack <= ack;
    o_notify <= note;
    o_payload <= pay;
    while (!done) begin
      @(negedge i_clk);
      done = i_ready;
      @(posedge i_clk);
    end
    o_valid <= 1'b0;
    o_opcode <= ~op;
    o_payload <= ~pay;
  endtask
endmodule // gw_thread_model
`default_nettype wire

// *** verification/thread_gateway_close_forward_test.sv ***
// Self-checking bench for the thread gateway.
`timescale 1ns/1ps
`default_nettype none
`include "gw_defines.svh"
module thread_gateway_close_forward_test;
  logic clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rf_be, wb_dw;
  logic waitreq, ready, valid, ack, note, rf_we, wb_v, nv, wv;
  logic [3:0] op, unit, rf_unit, wb_unit;
  logic [2:0] thr, rf_thr, wb_thr;
  logic [7:0] rf_reg;
  logic [6:0] nt_id;
  logic [255:0] pay, rf_data;
  int miscompares = 0, n_compared = 0, rf_n = 0, wb_n = 0, nt_n = 0, wk_n = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  thread_gateway_close_forward thread_gateway_close_forward_inst (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hF),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
    .I_MSG_VALID(valid), .O_MSG_READY(ready), .I_MSG_OPCODE(op),
    .I_MSG_UNIT(unit), .I_MSG_THREAD(thr), .I_MSG_ACK_REQ(ack),
    .I_MSG_NOTIFY(note), .I_MSG_PAYLOAD(pay), .O_WB_VALID(wb_v),
    .O_WB_UNIT(wb_unit), .O_WB_THREAD(wb_thr), .O_WB_DWORD(wb_dw),
    .O_RF_WE(rf_we), .O_RF_UNIT(rf_unit), .O_RF_THREAD(rf_thr),
    .O_RF_REG(rf_reg), .O_RF_BYTE_EN(rf_be), .O_RF_DATA(rf_data),
    .O_NOTIFY_VALID(nv), .O_WAKE_VALID(wv), .O_NOTE_UNIT(nt_id[6:3]),
    .O_NOTE_THREAD(nt_id[2:0]));
  gw_thread_model gw_thread_model_inst (.i_clk(clk), .i_ready(ready),
    .o_valid(valid), .o_opcode(op), .o_unit(unit), .o_thread(thr),
    .o_ack(ack), .o_notify(note), .o_payload(pay));
  // Pulses last one cycle, so they are caught mid-cycle where settled.
  always @(negedge clk) begin
    if (rf_we === 1'b1) rf_n++;
    if (wb_v === 1'b1) wb_n++;
    if (nv === 1'b1) nt_n++;
    if (wv === 1'b1) wk_n++;
  end
  task automatic check(input string name, input logic [255:0] got,
      input logic [255:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Request held until the edge at which waitrequest is seen low.
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
    logic done;
    done = 1'b0;
    q = '0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    while (!done) begin
      @(negedge clk);
      done = (waitreq === 1'b0);
      q = rdata;
      @(posedge clk);
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Sender keeps offset, length and recipient fields legal.
  function automatic logic [255:0] fwd(input logic [3:0] u,
      input logic [2:0] t, input logic [7:0] r, input logic [4:0] s,
      input logic [2:0] l);
    fwd = '0;
    fwd[127:0] = 128'hfedc_ba98_7654_3210_0123_4567_89ab_cdef;
    {fwd[155:152], fwd[146:144]} = {u, t};
    {fwd[188:181], fwd[180:176], fwd[170:168]} = {r, s, l};
  endfunction
  function automatic logic [255:0] lanes(input logic [31:0] be);
    for (int i = 0; i < 32; i++) lanes[8*i +: 8] = {8{be[i]}};
  endfunction
  task automatic close_out;
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(25 * 4000);
    miscompares++;
    close_out;
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [31:0] q, m;
    logic [4:0] s;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b0, `GW_REG_CTRL, '0, q);
    check("ctrl", q, `GW_CTRL_RST);
    bus(1'b0, `GW_REG_WAKE, '0, q);
    check("wake", q, {24'h00_0000, `GW_WAKE_RST});
    bus(1'b1, `GW_REG_SFID, 32'h0000_0009, q);
    bus(1'b1, `GW_REG_WAKE, 32'h0000_0002, q);
    bus(1'b0, `GW_REG_SFID, '0, q);
    check("sfid", q, 32'h0000_0009);
    bus(1'b0, 5'h18, '0, q);
    check("unmapped", q, 32'h0000_0000);
    gw_thread_model_inst.send(`GW_OP_OPEN, 4'h2, 3'h3, 1'b0, 1'b0,
      fwd(4'h0, 3'h0, 8'h10, 5'h00, 3'h0));
    for (int l = 0; l < 5; l++) begin
      s = (l == 0) ? 5'h13 : 5'h10;
      m = (32'h0000_0002 << (2 ** l - 1)) - 32'h0000_0001;
      if (l == 0) m = 32'h0000_0001;
      gw_thread_model_inst.send(`GW_OP_FORWARD, 4'h1, 3'h0, 1'b1, 1'b1,
        fwd(4'h2, 3'h3, 8'h03, s, 3'(l)));
      repeat (4) @(posedge clk);
      check("reg", rf_reg, 8'h13);
      check("unit", {rf_unit, rf_thr, nt_id}, 14'h0993);
      check("lanes", rf_be, m << s);
      check("data", rf_data & lanes(m << s), lanes(m << s) &
        fwd(4'h2, 3'h3, 8'h03, s, 3'(l)) << (8 * s));
      check("wb", {wb_unit, wb_dw}, 36'h1_0009_0000);
    end
    check("rf_n", rf_n, 5);
    check("wb_n", wb_n, 5);
    check("nt_n", nt_n, 5);
    check("wk_n", wk_n, 2);
    gw_thread_model_inst.send(`GW_OP_CLOSE, 4'h2, 3'h3, 1'b1, 1'b0, '1);
    repeat (4) @(posedge clk);
    check("close", {wb_unit, wb_thr, wb_dw}, 39'h13_0009_0000);
    gw_thread_model_inst.send(`GW_OP_FORWARD, 4'h1, 3'h0, 1'b1, 1'b1,
      fwd(4'h2, 3'h3, 8'h03, 5'h10, 3'h2));
    repeat (4) @(posedge clk);
    check("closed", {rf_n[7:0], wb_n[7:0]}, 16'h0506);
    bus(1'b0, `GW_REG_DROPCNT, '0, q);
    check("drop", q, 32'h0000_0001);
    gw_thread_model_inst.send(4'h7, 4'h1, 3'h0, 1'b1, 1'b0, '0);
    repeat (4) @(posedge clk);
    check("badop", {wb_n[7:0], wb_dw}, 40'h07_0009_0005);
    gw_thread_model_inst.send(`GW_OP_CLOSE, 4'h1, 3'h0, 1'b0, 1'b0, '0);
    repeat (4) @(posedge clk);
    check("noack", wb_n, 7);
    close_out;
  end
endmodule // thread_gateway_close_forward_test
bind thread_gateway_close_forward gw_checker gw_checker_inst (
  .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_AVS_READ(I_AVS_READ),
  .I_AVS_WRITE(I_AVS_WRITE), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .I_MSG_VALID(I_MSG_VALID), .O_MSG_READY(O_MSG_READY),
  .I_MSG_OPCODE(I_MSG_OPCODE), .I_MSG_UNIT(I_MSG_UNIT),
  .I_MSG_ACK_REQ(I_MSG_ACK_REQ), .I_MSG_NOTIFY(I_MSG_NOTIFY),
  .I_MSG_PAYLOAD(I_MSG_PAYLOAD), .O_WB_VALID(O_WB_VALID),
  .O_WB_UNIT(O_WB_UNIT), .O_WB_DWORD(O_WB_DWORD), .O_RF_WE(O_RF_WE),
  .O_RF_UNIT(O_RF_UNIT), .O_RF_THREAD(O_RF_THREAD),
  .O_RF_BYTE_EN(O_RF_BYTE_EN), .O_NOTIFY_VALID(O_NOTIFY_VALID),
  .O_WAKE_VALID(O_WAKE_VALID));
`default_nettype wire
